// ==== rms_mode_select.sv ====
// operating-mode selection, mode pin control, timing select and apb registers
`timescale 1ns/1ps

// What this block does
// RULE1 - auto mode: drive smpte valid pin, high only when locked to smpte input
// RULE2 - manual mode: release smpte valid pin and sample it as an input
// RULE3 - manual, smpte valid low: no smpte handling, video processing disabled
// RULE4 - manual, smpte valid high: smpte handling and video processing enabled
// RULE5 - manual, both mode pins low: data-through mode, no smpte or asi work
// RULE6 - manual, asi select high: perform asi extraction and processing
// RULE7 - controller holds smpte valid low whenever it drives asi select high
// RULE8 - auto mode: drive asi select pin low, asi streams unsupported
// RULE9 - timing select high: output hsync, vsync, de instead of h, v, f
// RULE10 - provide buffered copy of 27MHz crystal reference for cascading
// RULE11 - asi mode: upper half of twenty-bit output is undefined
// RULE12 - both mode pins high in manual mode: smpte wins, asi ignored
module rms_mode_select
    import rms_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // smpte valid pin, two-way
    input wire logic smpte_valid_pin_in,
    output logic smpte_valid_pin_out,
    output logic smpte_valid_pin_oe,
    // asi select pin, two-way
    input wire logic asi_select_pin_in,
    output logic asi_select_pin_out,
    output logic asi_select_pin_oe,
    // timing format select pin
    input wire logic timing_format_select,
    // lock indication from the receive path
    input wire logic smpte_lock,
    // timing from the processing path
    input wire logic hvf_h,
    input wire logic hvf_v,
    input wire logic hvf_f,
    input wire logic cea_hsync,
    input wire logic cea_vsync,
    input wire logic cea_de,
    // timing outputs
    output logic timing_out_h_hsync,
    output logic timing_out_v_vsync,
    output logic timing_out_f_de,
    // mode enables to the processing path
    output logic smpte_proc_en,
    output logic video_proc_en,
    output logic asi_proc_en,
    output logic data_through_en,
    output logic upper_half_undefined,
    // crystal reference
    input wire logic crystal_ref_in,
    output logic crystal_buffer_out
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [RMS_SYNC_W-1:0] pin_async;
    logic [RMS_SYNC_W-1:0] pin_sync;

    assign pin_async[RMS_SYNC_SMPTE] = smpte_valid_pin_in;
    assign pin_async[RMS_SYNC_ASI] = asi_select_pin_in;
    assign pin_async[RMS_SYNC_TFS] = timing_format_select;

    rms_sync #(
        .WIDTH(RMS_SYNC_W)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_async),
        .sync_out(pin_sync)
    );

    wire smpte_pin_s = pin_sync[RMS_SYNC_SMPTE];
    wire asi_pin_s = pin_sync[RMS_SYNC_ASI];
    wire tfs_s = pin_sync[RMS_SYNC_TFS];

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic auto_manual_bit;
    logic [RMS_INT_W-1:0] int_status;
    logic [RMS_INT_W-1:0] int_mask;
    rms_mode_t mode;
    logic lock_q;
    logic conflict_q;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire [RMS_ADDR_W-1:0] addr_lo = paddr[RMS_ADDR_W-1:0];
    wire addr_high_zero = (paddr[31:RMS_ADDR_W] == '0);
    wire setup_phase = psel && !penable;
    wire access_done = psel && penable && pready;
    wire hit_ctrl = addr_high_zero && (addr_lo == RMS_ADDR_CTRL);
    wire hit_status = addr_high_zero && (addr_lo == RMS_ADDR_STATUS);
    wire hit_int_status = addr_high_zero && (addr_lo == RMS_ADDR_INT_STATUS);
    wire hit_int_mask = addr_high_zero && (addr_lo == RMS_ADDR_INT_MASK);
    wire hit_any = hit_ctrl || hit_status || hit_int_status || hit_int_mask;
    wire wr_done = access_done && pwrite && !pslverr;
    wire wr_ctrl = wr_done && hit_ctrl;
    wire wr_int_status = wr_done && hit_int_status;
    wire wr_int_mask = wr_done && hit_int_mask;

    // ------------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------------
    // manual mode: smpte pin first, then asi pin, else data-through
    wire manual_smpte = smpte_pin_s; // [RULE4] [RULE12]
    wire manual_asi = !smpte_pin_s && asi_pin_s; // [RULE6] [RULE12]
    // auto mode never selects asi; unlocked input falls back to data-through
    wire auto_smpte = smpte_lock; // [RULE8]
    rms_mode_t next_mode;
    assign next_mode = auto_manual_bit ?
        (auto_smpte ? RMS_MODE_SMPTE : RMS_MODE_THRU) :
        (manual_smpte ? RMS_MODE_SMPTE :
        (manual_asi ? RMS_MODE_ASI : RMS_MODE_THRU)); // [RULE3] [RULE5]

    // pin conflict: controller drives both mode pins high in manual mode
    wire next_conflict = !auto_manual_bit && smpte_pin_s && asi_pin_s; // [RULE7]

    // pin drive: outputs in auto mode, released in manual mode
    wire next_smpte_oe = auto_manual_bit; // [RULE1] [RULE2]
    wire next_smpte_out = auto_manual_bit && smpte_lock; // [RULE1]
    wire next_asi_oe = auto_manual_bit; // [RULE8]

    // ------------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------------
    logic [RMS_INT_W-1:0] events;
    assign events[RMS_INT_LOCK_BIT] = (smpte_lock != lock_q);
    assign events[RMS_INT_MODE_BIT] = (next_mode != mode);
    assign events[RMS_INT_CONFLICT_BIT] = next_conflict && !conflict_q;

    // set wins over write-one-to-clear
    wire [RMS_INT_W-1:0] clear_bits = wr_int_status ? pwdata[RMS_INT_W-1:0] : '0;
    wire [RMS_INT_W-1:0] next_int_status = (int_status & ~clear_bits) | events;
    wire [RMS_INT_W-1:0] next_int_mask = wr_int_mask ? pwdata[RMS_INT_W-1:0] : int_mask;
    wire next_irq = |(next_int_status & next_int_mask);

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] next_rdata;

    always_comb
    begin
        status_word = RMS_ZERO_WORD;
        status_word[RMS_ST_MODE_MSB:RMS_ST_MODE_LSB] = mode;
        status_word[RMS_ST_LOCK_BIT] = lock_q;
        status_word[RMS_ST_SMPTE_PIN_BIT] = smpte_pin_s;
        status_word[RMS_ST_ASI_PIN_BIT] = asi_pin_s;
        status_word[RMS_ST_TFS_BIT] = tfs_s;
        status_word[RMS_ST_CONFLICT_BIT] = conflict_q;
        status_word[RMS_ST_UPPER_UNDEF_BIT] = upper_half_undefined;
    end

    always_comb
    begin
        next_rdata = RMS_ZERO_WORD;
        if (hit_ctrl)
            next_rdata[RMS_CTRL_AUTO_BIT] = auto_manual_bit;
        else if (hit_status)
            next_rdata = status_word;
        else if (hit_int_status)
            next_rdata[RMS_INT_W-1:0] = int_status;
        else if (hit_int_mask)
            next_rdata[RMS_INT_W-1:0] = int_mask;
    end

    // ------------------------------------------------------------------
    // apb answer: ready in the first access cycle
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RMS_ZERO_WORD;
        end
        else
        begin
            pready <= setup_phase;
            pslverr <= setup_phase && !hit_any;
            if (setup_phase && !pwrite)
                prdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            auto_manual_bit <= RMS_AUTO_RESET;
            int_status <= RMS_INT_RESET;
            int_mask <= RMS_INT_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                auto_manual_bit <= pwdata[RMS_CTRL_AUTO_BIT];
            int_status <= next_int_status;
            int_mask <= next_int_mask;
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // mode state and pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= RMS_MODE_THRU;
            lock_q <= 1'b0;
            conflict_q <= 1'b0;
            smpte_valid_pin_oe <= RMS_AUTO_RESET;
            smpte_valid_pin_out <= 1'b0;
            asi_select_pin_oe <= RMS_AUTO_RESET;
            asi_select_pin_out <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            lock_q <= smpte_lock;
            conflict_q <= next_conflict;
            smpte_valid_pin_oe <= next_smpte_oe; // [RULE2]
            smpte_valid_pin_out <= next_smpte_out; // [RULE1]
            asi_select_pin_oe <= next_asi_oe;
            asi_select_pin_out <= 1'b0; // [RULE8]
        end
    end

    // ------------------------------------------------------------------
    // processing enables
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            smpte_proc_en <= 1'b0;
            video_proc_en <= 1'b0;
            asi_proc_en <= 1'b0;
            data_through_en <= 1'b1;
            upper_half_undefined <= 1'b0;
        end
        else
        begin
            smpte_proc_en <= (next_mode == RMS_MODE_SMPTE); // [RULE3] [RULE4]
            video_proc_en <= (next_mode == RMS_MODE_SMPTE); // [RULE3] [RULE4]
            asi_proc_en <= (next_mode == RMS_MODE_ASI); // [RULE6]
            data_through_en <= (next_mode == RMS_MODE_THRU); // [RULE5]
            upper_half_undefined <= (next_mode == RMS_MODE_ASI); // [RULE11]
        end
    end

    // ------------------------------------------------------------------
    // timing output select
    // ------------------------------------------------------------------
    wire next_t_a = tfs_s ? cea_hsync : hvf_h; // [RULE9]
    wire next_t_b = tfs_s ? cea_vsync : hvf_v; // [RULE9]
    wire next_t_c = tfs_s ? cea_de : hvf_f; // [RULE9]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timing_out_h_hsync <= 1'b0;
            timing_out_v_vsync <= 1'b0;
            timing_out_f_de <= 1'b0;
        end
        else
        begin
            timing_out_h_hsync <= next_t_a;
            timing_out_v_vsync <= next_t_b;
            timing_out_f_de <= next_t_c;
        end
    end

    // ------------------------------------------------------------------
    // crystal buffer
    // ------------------------------------------------------------------
    // a straight buffer: the reference is faster than pclk and cannot be resampled
    assign crystal_buffer_out = crystal_ref_in; // [RULE10]

endmodule

// ==== rms_mode_select_checker.sv ====
// assertions on pin direction, mode selection and timing output of the mode select block
`timescale 1ns/1ps

module rms_mode_select_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // mode pins and lock
    input wire logic smpte_valid_pin_in,
    input wire logic smpte_valid_pin_out,
    input wire logic smpte_valid_pin_oe,
    input wire logic asi_select_pin_in,
    input wire logic asi_select_pin_out,
    input wire logic asi_select_pin_oe,
    input wire logic smpte_lock,
    // timing inputs and outputs
    input wire logic timing_format_select,
    input wire logic hvf_h,
    input wire logic hvf_v,
    input wire logic hvf_f,
    input wire logic cea_hsync,
    input wire logic cea_vsync,
    input wire logic cea_de,
    input wire logic timing_out_h_hsync,
    input wire logic timing_out_v_vsync,
    input wire logic timing_out_f_de,
    // mode enables
    input wire logic smpte_proc_en,
    input wire logic video_proc_en,
    input wire logic asi_proc_en,
    input wire logic data_through_en,
    input wire logic upper_half_undefined,
    // crystal
    input wire logic crystal_ref_in,
    input wire logic crystal_buffer_out
);
    // ----------
    // helpers
    // ----------
    logic [1:0] up_cnt;
    logic up;

    // edges since reset release, so three-edge histories are valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            up_cnt <= 2'h0;
        else if (up_cnt != 2'h3)
            up_cnt <= up_cnt + 2'h1;
    end
    assign up = (up_cnt == 2'h3);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // controller has owned the pins for two cycles
    sequence in_manual;
        !smpte_valid_pin_oe ##1 !smpte_valid_pin_oe;
    endsequence

    // pin levels seen three edges back
    sequence pins_were(s, a);
        up && $past(smpte_valid_pin_in, 3) == s && $past(asi_select_pin_in, 3) == a;
    endsequence

    // ----------
    // assertions
    // ----------
    a_auto_lock_out: assert property (up && smpte_valid_pin_oe |->
        smpte_valid_pin_out == $past(smpte_lock)) else $error("valid pin not lock");
    a_manual_release: assert property (smpte_valid_pin_oe == asi_select_pin_oe &&
        (smpte_valid_pin_oe || !smpte_valid_pin_out)) else $error("pin not released");
    a_auto_asi_low: assert property (!asi_select_pin_out &&
        (!asi_select_pin_oe || !$past(asi_select_pin_oe) || !asi_proc_en))
        else $error("asi in auto mode");
    a_one_mode: assert property ($onehot({smpte_proc_en, asi_proc_en, data_through_en}) &&
        video_proc_en == smpte_proc_en) else $error("mode enables not one-hot");
    a_asi_mode: assert property (in_manual ##0 pins_were(1'b0, 1'b1) |->
        asi_proc_en && upper_half_undefined) else $error("asi mode missing");
    a_smpte_prio: assert property (in_manual ##0 up && $past(smpte_valid_pin_in, 3) |->
        smpte_proc_en && video_proc_en && !asi_proc_en) else $error("smpte mode missing");
    a_thru_mode: assert property (in_manual ##0 pins_were(1'b0, 1'b0) |->
        data_through_en && !video_proc_en) else $error("data-through missing");
    a_timing_sel: assert property (up |->
        {timing_out_h_hsync, timing_out_v_vsync, timing_out_f_de} ==
        ($past(timing_format_select, 3) ? $past({cea_hsync, cea_vsync, cea_de})
        : $past({hvf_h, hvf_v, hvf_f}))) else $error("timing select wrong");
    a_xtal_copy: assert property (crystal_buffer_out == crystal_ref_in)
        else $error("crystal copy wrong");
endmodule

bind rms_mode_select rms_mode_select_checker u_rms_mode_select_checker (.*);

// ==== rms_pin_ctrl.sv ====
// model of the board controller that owns the two mode pins in manual mode
`timescale 1ns/1ps

module rms_pin_ctrl (
    // device side of the pins
    input wire logic smpte_valid_pin_out,
    input wire logic smpte_valid_pin_oe,
    input wire logic asi_select_pin_out,
    input wire logic asi_select_pin_oe,
    // controller wishes
    input wire logic want_smpte,
    input wire logic want_asi,
    input wire logic allow_both,
    // resolved pin levels
    output logic smpte_valid_pin_in,
    output logic asi_select_pin_in
);
    // ----------
    // pin resolution
    // ----------
    logic drv_smpte;

    // smpte valid held low while asi select is driven high, unless allow_both is set
    assign drv_smpte = want_smpte && (!want_asi || allow_both);
    // device drives while enabled, controller drives otherwise
    assign smpte_valid_pin_in = smpte_valid_pin_oe ? smpte_valid_pin_out : drv_smpte;
    assign asi_select_pin_in = asi_select_pin_oe ? asi_select_pin_out : want_asi;
endmodule

// ==== rms_pkg.sv ====
// package of constants, register map and mode codes for the receiver mode select block
package rms_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] RMS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] RMS_ADDR_STATUS = 8'h04;
    localparam logic [7:0] RMS_ADDR_INT_STATUS = 8'h08;
    localparam logic [7:0] RMS_ADDR_INT_MASK = 8'h0c;
    localparam int RMS_ADDR_W = 8;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int RMS_CTRL_AUTO_BIT = 0;
    localparam logic RMS_AUTO_RESET = 1'b1;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int RMS_ST_MODE_LSB = 0;
    localparam int RMS_ST_MODE_MSB = 2;
    localparam int RMS_ST_LOCK_BIT = 3;
    localparam int RMS_ST_SMPTE_PIN_BIT = 4;
    localparam int RMS_ST_ASI_PIN_BIT = 5;
    localparam int RMS_ST_TFS_BIT = 6;
    localparam int RMS_ST_CONFLICT_BIT = 7;
    localparam int RMS_ST_UPPER_UNDEF_BIT = 8;

    // ------------------------------------------------------------------
    // interrupt status and mask fields (same layout)
    // ------------------------------------------------------------------
    localparam int RMS_INT_W = 3;
    localparam int RMS_INT_LOCK_BIT = 0;
    localparam int RMS_INT_MODE_BIT = 1;
    localparam int RMS_INT_CONFLICT_BIT = 2;
    localparam logic [RMS_INT_W-1:0] RMS_INT_RESET = 3'h0;

    // ------------------------------------------------------------------
    // synchronised pin inputs
    // ------------------------------------------------------------------
    localparam int RMS_SYNC_W = 3;
    localparam int RMS_SYNC_SMPTE = 0;
    localparam int RMS_SYNC_ASI = 1;
    localparam int RMS_SYNC_TFS = 2;

    // ------------------------------------------------------------------
    // operating modes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RMS_MODE_SMPTE = 3'b001,
        RMS_MODE_ASI = 3'b010,
        RMS_MODE_THRU = 3'b100
    } rms_mode_t;

    localparam logic [31:0] RMS_ZERO_WORD = 32'h0000_0000;

endpackage

// ==== rms_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps

module rms_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous inputs and synchronised copies
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ==== tb_top.sv ====
// self-checking bench for the receiver mode select block
`timescale 1ns/1ps

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, (e), (g)); end end

module tb_top;
    import rms_pkg::*;
    // ----------
    // signals
    // ----------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic pready, pslverr, irq, err;
    logic smpte_valid_pin_in, smpte_valid_pin_out, smpte_valid_pin_oe;
    logic asi_select_pin_in, asi_select_pin_out, asi_select_pin_oe;
    logic timing_format_select = 1'b0, smpte_lock = 1'b0, crystal_ref_in = 1'b0;
    logic hvf_h = 1'b0, hvf_v = 1'b0, hvf_f = 1'b0, cea_hsync = 1'b0, cea_vsync = 1'b0;
    logic cea_de = 1'b0, crystal_buffer_out, timing_out_h_hsync, timing_out_v_vsync;
    logic timing_out_f_de, smpte_proc_en, video_proc_en, asi_proc_en, data_through_en;
    logic upper_half_undefined, want_smpte = 1'b0, want_asi = 1'b0, allow_both = 1'b0;
    logic [2:0] exp_mode;
    int num_errors = 0, comparisons = 0, cycles = 0;

    rms_mode_select u_rms_mode_select (.*);
    rms_pin_ctrl u_rms_pin_ctrl (.*);

    // clocks and hang limit
    always #25 pclk = ~pclk;
    always #18.5 crystal_ref_in = ~crystal_ref_in;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    // ----------
    // tasks
    // ----------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, '0);
        `CHK(nm, e, rd)
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------
    // tests
    // ----------
    initial
    begin
        wt(4);
        `CHK("rst pin oe", 1'b1, smpte_valid_pin_oe)
        `CHK("rst asi oe", 1'b1, asi_select_pin_oe)
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(RMS_ADDR_CTRL, 32'h1, "ctrl reset");
        rdc(RMS_ADDR_INT_MASK, 32'h0, "mask reset");
        // auto mode: valid pin follows lock, asi pin low
        for (int i = 0; i < 2; i++)
        begin
            @(posedge pclk);
            smpte_lock <= (i == 0);
            wt(4);
            `CHK("valid pin", (i == 0), smpte_valid_pin_in)
            `CHK("asi pin", 1'b0, asi_select_pin_in)
            `CHK("auto smpte", (i == 0), smpte_proc_en)
            `CHK("auto asi", 1'b0, asi_proc_en)
        end
        // interrupt raise, mask and clear
        apb(1'b1, RMS_ADDR_INT_STATUS, 32'h7);
        rdc(RMS_ADDR_INT_STATUS, 32'h0, "int cleared");
        apb(1'b1, RMS_ADDR_INT_MASK, 32'h2);
        @(posedge pclk);
        smpte_lock <= 1'b1;
        wt(6);
        `CHK("irq set", 1'b1, irq)
        rdc(RMS_ADDR_INT_STATUS, 32'h3, "int status");
        apb(1'b1, RMS_ADDR_INT_MASK, 32'h0);
        wt(2);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, RMS_ADDR_INT_MASK, 32'h2);
        wt(2);
        `CHK("irq unmasked", 1'b1, irq)
        apb(1'b1, RMS_ADDR_INT_STATUS, 32'h3);
        wt(2);
        `CHK("irq cleared", 1'b0, irq)
        // manual mode: every pin combination
        apb(1'b1, RMS_ADDR_CTRL, 32'h0);
        wt(2);
        `CHK("manual oe", 2'b00, {smpte_valid_pin_oe, asi_select_pin_oe})
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            want_smpte <= i[0];
            want_asi <= i[1];
            allow_both <= i[0] & i[1];
            exp_mode = i[0] ? 3'b001 : (i[1] ? 3'b010 : 3'b100);
            wt(5);
            `CHK("smpte en", exp_mode[0], smpte_proc_en)
            `CHK("video en", exp_mode[0], video_proc_en)
            `CHK("asi en", exp_mode[1], asi_proc_en)
            `CHK("thru en", exp_mode[2], data_through_en)
            `CHK("upper undef", exp_mode[1], upper_half_undefined)
            rdc(RMS_ADDR_STATUS, {23'h0, exp_mode[1], i[0] & i[1], 1'b0, i[1], i[0], 1'b1,
                exp_mode}, "status");
        end
        // timing select with two input patterns
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            timing_format_select <= i[1];
            {hvf_h, hvf_v, hvf_f, cea_hsync, cea_vsync, cea_de} <= i[0] ? 6'h2a : 6'h15;
            wt(4);
            exp_mode = i[1] ? {cea_hsync, cea_vsync, cea_de} : {hvf_h, hvf_v, hvf_f};
            `CHK("timing", exp_mode, {timing_out_h_hsync, timing_out_v_vsync, timing_out_f_de})
        end
        // refused and ignored accesses
        apb(1'b0, 8'h10, '0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, RMS_ADDR_STATUS, 32'hffff_ffff);
        `CHK("status wr err", 1'b0, err)
        repeat (2)
        begin
            @(crystal_ref_in);
            #0.1;
            `CHK("xtal copy", crystal_ref_in, crystal_buffer_out)
        end
        apb(1'b1, RMS_ADDR_CTRL, 32'h1);
        wt(2);
        `CHK("auto oe", 1'b1, smpte_valid_pin_oe)
        give_verdict();
    end
endmodule
